/* hdl/synth_port_params.svh */
// Operation
// - Device samples data MSB first on clock rise
// - Host idles enable high, lowers it first
// - Enable rise commits by count: 8/16/15/24
// - Registers change only at frame end
// - 24-bit divider frame drops first nine bits
// - Device echoes bits on clock falling edges
// - Host always writes 64 to setup byte
// - Host serial clock at most 4 MHz
// - Host moves enable only while clock low
// - Output equals reference times multiplier over divider
// - Host keeps divider within 1600 to 2500
// - Host keeps output within 100 to 160 MHz; checked only on multiplier writes, against the last divider sent
// - Registers written singly, any order
// - Programmed frequency holds once all three written
// - New frequency settles within 5 ms
// - Unprogrammed output free runs, 80 to 120 MHz
`ifndef SYNTH_PORT_PARAMS_SVH
`define SYNTH_PORT_PARAMS_SVH

//--------------------------------------------------------------
// Timing
//--------------------------------------------------------------
`define SP_MCLK_KHZ 50000
`define SP_MCLK_NS 20
`define SP_SCLK_MAX_KHZ 4000
`define SP_HALF_CYCLES ((`SP_MCLK_KHZ + 2 * `SP_SCLK_MAX_KHZ - 1) / (2 * `SP_SCLK_MAX_KHZ))
`define SP_EN_SETUP_NS 100
`define SP_EN_HIGH_NS 300
`define SP_LEAD_TICKS ((`SP_EN_SETUP_NS + `SP_HALF_CYCLES * `SP_MCLK_NS - 1) / (`SP_HALF_CYCLES * `SP_MCLK_NS))
`define SP_GAP_TICKS ((`SP_EN_HIGH_NS + `SP_HALF_CYCLES * `SP_MCLK_NS - 1) / (`SP_HALF_CYCLES * `SP_MCLK_NS))
`define SP_SETTLE_MS 5
`define SP_SETTLE_CYCLES (`SP_SETTLE_MS * `SP_MCLK_KHZ)

//--------------------------------------------------------------
// Frame lengths and fields
//--------------------------------------------------------------
`define SP_LEN_SETUP 5'h08
`define SP_LEN_MULT 5'h10
`define SP_LEN_DIV_SHORT 5'h0F
`define SP_LEN_DIV_LONG 5'h18
`define SP_DIV_SKIP 9
`define SP_SETUP_VALUE 8'h40

//--------------------------------------------------------------
// Frequency plan, kHz
//--------------------------------------------------------------
`define SP_REF_KHZ 32'h0000_2710
`define SP_OUT_MIN_KHZ 32'h0001_86A0
`define SP_OUT_MAX_KHZ 32'h0002_7100
`define SP_FREE_RUN_KHZ 32'h0001_86A0
`define SP_DIV_MIN 15'h0640
`define SP_DIV_MAX 15'h09C4
`define SP_HOST_DIV_INIT 15'h07D0

//--------------------------------------------------------------
// Reset values
//--------------------------------------------------------------
`define SP_ENABLE_IDLE 1'b1

`endif

/* hdl/synth_port_pkg.sv */
package synth_port_pkg;

	// Frame kinds the host can send
	typedef enum logic [1:0] {
		KIND_SETUP = 2'h0,
		KIND_MULT = 2'h1,
		KIND_DIV15 = 2'h2,
		KIND_DIV24 = 2'h3
	} frame_kind_t;

	// Host sequencer, Gray along the frame
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_LEAD = 3'h1,
		H_LOW = 3'h3,
		H_HIGH = 3'h2,
		H_TAIL = 3'h6,
		H_GAP = 3'h7
	} host_state_t;

endpackage : synth_port_pkg

/* hdl/synth_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface synth_link_if;
	logic sclk;
	logic enableN;
	logic sdata;
	logic dataOut;
	logic dataOutOe;
	logic dataLine;

	// Tristate echo line, shows the inverse when released
	assign dataLine = dataOutOe ? dataOut : ~dataOut;

	modport device (
		input sclk,
		input enableN,
		input sdata,
		output dataOut,
		output dataOutOe
	);

	modport host (
		output sclk,
		output enableN,
		output sdata,
		input dataLine
	);
endinterface : synth_link_if

`default_nettype wire

/* hdl/sync_2ff.sv */
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async,
	output logic [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	//--------------------------------------------------------------
	// Two flops, first read only by second
	//--------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			meta_q <= INIT;
			sync_q <= INIT;
		end
		else
		begin
			meta_q <= async;
			sync_q <= meta_q;
		end
	end

	assign synced = sync_q;
endmodule : sync_2ff

`default_nettype wire

/* hdl/synth_port_device.sv */
`timescale 1ns/1ps
`default_nettype none
`include "synth_port_params.svh"

module synth_port_device #(
	parameter int SETTLE_CYCLES = `SP_SETTLE_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	synth_link_if.device link,
	output logic [7:0] setupByte,
	output logic [15:0] loopMultiplier,
	output logic [14:0] baseDivide,
	output logic configured,
	output logic freeRun,
	output logic settling,
	output logic locked,
	output logic [31:0] outFreqKhz,
	output logic commitPulse,
	output logic rejectPulse
);
	import synth_port_pkg::*;

	// Reference times multiplier over divider, in kHz
	function automatic logic [31:0] targetKhz(input logic [15:0] mult,
		input logic [14:0] div);
		logic [31:0] prod;
		prod = `SP_REF_KHZ * {16'h0000, mult};
		if (div == 15'h0000)
			targetKhz = 32'h0000_0000;
		else
			targetKhz = prod / {17'h00000, div};
	endfunction : targetKhz

	//--------------------------------------------------------------
	// Pin synchronisers and edge detect
	//--------------------------------------------------------------
	logic [2:0] pinsSync;
	logic sclkS;
	logic enNS;
	logic sdataS;
	logic sclkPrev_q;
	logic enNPrev_q;
	logic sclkRise;
	logic sclkFall;
	logic enFall;
	logic enRise;

	sync_2ff #(
		.WIDTH(3),
		.INIT({1'b0, `SP_ENABLE_IDLE, 1'b0})
	) u_sync (
		.mclk(mclk),
		.reset(reset),
		.async({link.sclk, link.enableN, link.sdata}),
		.synced(pinsSync)
	);

	assign sclkS = pinsSync[2];
	assign enNS = pinsSync[1];
	assign sdataS = pinsSync[0];
	assign sclkRise = sclkS & ~sclkPrev_q;
	assign sclkFall = ~sclkS & sclkPrev_q;
	assign enFall = ~enNS & enNPrev_q;
	assign enRise = enNS & ~enNPrev_q;

	// Previous levels for edge detection
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			sclkPrev_q <= 1'b0;
			enNPrev_q <= `SP_ENABLE_IDLE;
		end
		else
		begin
			sclkPrev_q <= sclkS;
			enNPrev_q <= enNS;
		end
	end

	//--------------------------------------------------------------
	// Shifter, counter, commit
	//--------------------------------------------------------------
	logic [23:0] shift_q, shift_d;
	logic [4:0] count_q, count_d;
	logic open_q, open_d;
	logic echo_q, echo_d;
	logic [7:0] setup_q, setup_d;
	logic [15:0] mult_q, mult_d;
	logic [14:0] div_q, div_d;
	logic [2:0] written_q, written_d;
	logic commit_q, commit_d;
	logic reject_q, reject_d;

	// Next state of the serial front end
	always_comb
	begin
		shift_d = shift_q;
		count_d = count_q;
		open_d = open_q;
		echo_d = echo_q;
		setup_d = setup_q;
		mult_d = mult_q;
		div_d = div_q;
		written_d = written_q;
		commit_d = 1'b0;
		reject_d = 1'b0;
		if (enFall)
		begin
			open_d = 1'b1;
			count_d = 5'h00;
			shift_d = 24'h00_0000;
		end
		else if (open_q && !enNS && sclkRise)
		begin
			shift_d = {shift_q[22:0], sdataS};
			if (count_q != 5'h1F)
				count_d = count_q + 5'h01;
		end
		// Echo last bit taken on each falling edge
		if (open_q && !enNS && sclkFall)
			echo_d = shift_q[0];
		// Registers move only at enable rise
		if (enRise && open_q)
		begin
			open_d = 1'b0;
			commit_d = 1'b1;
			case (count_q)
				`SP_LEN_SETUP:
				begin
					setup_d = shift_q[7:0];
					written_d[0] = 1'b1;
				end
				`SP_LEN_MULT:
				begin
					mult_d = shift_q[15:0];
					written_d[1] = 1'b1;
				end
				`SP_LEN_DIV_SHORT, `SP_LEN_DIV_LONG:
				begin
					div_d = shift_q[14:0];
					written_d[2] = 1'b1;
				end
				default:
				begin
					commit_d = 1'b0;
					reject_d = 1'b1;
				end
			endcase
		end
	end

	// Front end registers
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			shift_q <= 24'h00_0000;
			count_q <= 5'h00;
			open_q <= 1'b0;
			echo_q <= 1'b0;
			setup_q <= 8'h00;
			mult_q <= 16'h0000;
			div_q <= 15'h0000;
			written_q <= 3'h0;
			commit_q <= 1'b0;
			reject_q <= 1'b0;
		end
		else
		begin
			shift_q <= shift_d;
			count_q <= count_d;
			open_q <= open_d;
			echo_q <= echo_d;
			setup_q <= setup_d;
			mult_q <= mult_d;
			div_q <= div_d;
			written_q <= written_d;
			commit_q <= commit_d;
			reject_q <= reject_d;
		end
	end

	//--------------------------------------------------------------
	// Synthesizer model: settle timer and output rate
	//--------------------------------------------------------------
	logic [31:0] settle_q, settle_d;
	logic [31:0] freq_q, freq_d;
	logic allWritten;

	assign allWritten = &written_q;

	// Settling starts on every commit once programmed
	always_comb
	begin
		settle_d = settle_q;
		freq_d = freq_q;
		if (!allWritten)
			freq_d = `SP_FREE_RUN_KHZ;
		else if (commit_q)
			settle_d = 32'(SETTLE_CYCLES);
		else if (settle_q > 32'h0000_0001)
			settle_d = settle_q - 32'h0000_0001;
		else if (settle_q == 32'h0000_0001)
		begin
			settle_d = 32'h0000_0000;
			freq_d = targetKhz(mult_q, div_q);
		end
	end

	// Synthesizer registers
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			settle_q <= 32'h0000_0000;
			freq_q <= `SP_FREE_RUN_KHZ;
		end
		else
		begin
			settle_q <= settle_d;
			freq_q <= freq_d;
		end
	end

	//--------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------
	assign link.dataOut = echo_q;
	assign link.dataOutOe = open_q; // Drives only inside a frame
	assign setupByte = setup_q;
	assign loopMultiplier = mult_q;
	assign baseDivide = div_q;
	assign configured = allWritten;
	assign freeRun = ~allWritten;
	assign settling = allWritten & (settle_q != 32'h0000_0000);
	assign locked = allWritten & (settle_q == 32'h0000_0000);
	assign outFreqKhz = freq_q;
	assign commitPulse = commit_q;
	assign rejectPulse = reject_q;
endmodule : synth_port_device

`default_nettype wire

/* hdl/synth_port_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "synth_port_params.svh"

module synth_port_host (
	input wire logic mclk,
	input wire logic reset,
	synth_link_if.host link,
	input wire logic start,
	input wire synth_port_pkg::frame_kind_t kind,
	input wire logic [23:0] word,
	output logic busy,
	output logic done,
	output logic refused,
	output logic [23:0] echo,
	output logic echoMatch
);
	import synth_port_pkg::*;

	localparam logic [3:0] HALF = 4'(`SP_HALF_CYCLES);
	localparam logic [1:0] LEAD = 2'(`SP_LEAD_TICKS);
	localparam logic [1:0] GAP = 2'(`SP_GAP_TICKS);

	host_state_t st_q, st_d;
	logic [3:0] div_q, div_d;
	logic [1:0] ph_q, ph_d;
	logic [23:0] tx_q, tx_d;
	logic [23:0] sent_q, sent_d;
	logic [23:0] echo_q, echo_d;
	logic [23:0] mask_q, mask_d;
	logic [4:0] left_q, left_d;
	logic [4:0] len_q, len_d;
	logic [14:0] lastDiv_q, lastDiv_d;
	logic sclk_q, sclk_d;
	logic enN_q, enN_d;
	logic sd_q, sd_d;
	logic done_q, done_d;
	logic ref_q, ref_d;
	logic match_q, match_d;
	logic tick;
	logic [4:0] len;
	logic [23:0] val;
	logic ok;
	logic [31:0] outK;
	logic [31:0] loK;
	logic [31:0] hiK;

	assign tick = (st_q != H_IDLE) && (div_q == HALF - 4'h1);

	//--------------------------------------------------------------
	// Request decode and range checks
	//--------------------------------------------------------------
	always_comb
	begin
		outK = `SP_REF_KHZ * {16'h0000, word[15:0]};
		loK = `SP_OUT_MIN_KHZ * {17'h00000, lastDiv_q};
		hiK = `SP_OUT_MAX_KHZ * {17'h00000, lastDiv_q};
		ok = 1'b1;
		case (kind)
			KIND_SETUP:
			begin
				len = `SP_LEN_SETUP;
				val = {16'h0000, `SP_SETUP_VALUE};
			end
			KIND_MULT:
			begin
				len = `SP_LEN_MULT;
				val = {8'h00, word[15:0]};
				ok = (outK >= loK) && (outK <= hiK);
			end
			KIND_DIV15:
			begin
				len = `SP_LEN_DIV_SHORT;
				val = {9'h000, word[14:0]};
			end
			default:
			begin
				len = `SP_LEN_DIV_LONG;
				val = {9'h000, word[14:0]};
			end
		endcase
		if (kind == KIND_DIV15 || kind == KIND_DIV24)
			ok = (word[14:0] >= `SP_DIV_MIN) && (word[14:0] <= `SP_DIV_MAX);
	end

	//--------------------------------------------------------------
	// Frame sequencer
	//--------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		div_d = (st_q == H_IDLE || tick) ? 4'h0 : div_q + 4'h1;
		ph_d = ph_q;
		tx_d = tx_q;
		sent_d = sent_q;
		echo_d = echo_q;
		mask_d = mask_q;
		left_d = left_q;
		len_d = len_q;
		lastDiv_d = lastDiv_q;
		sclk_d = sclk_q;
		enN_d = enN_q;
		sd_d = sd_q;
		done_d = 1'b0;
		ref_d = 1'b0;
		match_d = match_q;
		case (st_q)
			H_IDLE:
			if (start && !ok)
				ref_d = 1'b1;
			else if (start)
			begin
				tx_d = val << (5'h18 - len);
				sent_d = val;
				mask_d = ~(24'hFF_FFFF << len);
				left_d = len;
				len_d = len;
				echo_d = 24'h00_0000;
				if (kind == KIND_DIV15 || kind == KIND_DIV24)
					lastDiv_d = word[14:0];
				enN_d = 1'b0;
				ph_d = 2'h0;
				st_d = H_LEAD;
			end
			H_LEAD:
			if (tick)
			begin
				ph_d = ph_q + 2'h1;
				if (ph_q + 2'h1 >= LEAD)
				begin
					sd_d = tx_q[23];
					tx_d = {tx_q[22:0], 1'b0};
					st_d = H_LOW;
				end
			end
			H_LOW:
			if (tick)
			begin
				if (left_q != len_q)
					echo_d = {echo_q[22:0], link.dataLine};
				sclk_d = 1'b1;
				st_d = H_HIGH;
			end
			H_HIGH:
			if (tick)
			begin
				sclk_d = 1'b0;
				left_d = left_q - 5'h01;
				if (left_q == 5'h01)
					st_d = H_TAIL;
				else
				begin
					sd_d = tx_q[23];
					tx_d = {tx_q[22:0], 1'b0};
					st_d = H_LOW;
				end
			end
			H_TAIL:
			if (tick)
			begin
				echo_d = {echo_q[22:0], link.dataLine};
				enN_d = 1'b1;
				sd_d = 1'b0;
				ph_d = 2'h0;
				st_d = H_GAP;
			end
			H_GAP:
			if (tick)
			begin
				ph_d = ph_q + 2'h1;
				if (ph_q + 2'h1 >= GAP)
				begin
					match_d = ((echo_q ^ sent_q) & mask_q) == 24'h00_0000;
					done_d = 1'b1;
					st_d = H_IDLE;
				end
			end
			default:
				st_d = H_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			st_q <= H_IDLE;
			div_q <= 4'h0;
			ph_q <= 2'h0;
			tx_q <= 24'h00_0000;
			sent_q <= 24'h00_0000;
			echo_q <= 24'h00_0000;
			mask_q <= 24'h00_0000;
			left_q <= 5'h00;
			len_q <= 5'h00;
			lastDiv_q <= `SP_HOST_DIV_INIT;
			sclk_q <= 1'b0;
			enN_q <= `SP_ENABLE_IDLE;
			sd_q <= 1'b0;
			done_q <= 1'b0;
			ref_q <= 1'b0;
			match_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			div_q <= div_d;
			ph_q <= ph_d;
			tx_q <= tx_d;
			sent_q <= sent_d;
			echo_q <= echo_d;
			mask_q <= mask_d;
			left_q <= left_d;
			len_q <= len_d;
			lastDiv_q <= lastDiv_d;
			sclk_q <= sclk_d;
			enN_q <= enN_d;
			sd_q <= sd_d;
			done_q <= done_d;
			ref_q <= ref_d;
			match_q <= match_d;
		end
	end

	assign link.sclk = sclk_q;
	assign link.enableN = enN_q;
	assign link.sdata = sd_q;
	assign busy = (st_q != H_IDLE);
	assign done = done_q;
	assign refused = ref_q;
	assign echo = echo_q;
	assign echoMatch = match_q;
endmodule : synth_port_host

`default_nettype wire

/* tb/synth_port_props.sv */
`timescale 1ns/1ps
`default_nettype none

module synth_port_props (
	input wire logic mclk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic enableN,
	input wire logic sdata,
	input wire logic dataOut,
	input wire logic dataOutOe,
	input wire logic dataLine
);
	logic sclkPrev_q, sclkPrev_d, heldBit_q, heldBit_d;
	logic [4:0] count_q, count_d;

	//------------------------------
	// Frame watcher
	//------------------------------
	// Counts clock rises per frame, keeps last bit
	always_comb
	begin
		sclkPrev_d = sclk;
		heldBit_d = heldBit_q;
		count_d = enableN ? 5'h00 : count_q;
		if (!enableN && sclk && !sclkPrev_q)
		begin
			count_d = count_q + 5'h01;
			heldBit_d = sdata;
		end
	end

	// Watcher registers
	always_ff @(posedge mclk)
	begin
		sclkPrev_q <= sclkPrev_d;
		heldBit_q <= heldBit_d;
		count_q <= count_d;
	end

	default clocking dc @(posedge mclk); endclocking
	default disable iff (reset);

	chk_clock_in_frame: assert property ($rose(sclk) |-> !enableN)
		else $error("clock rose outside a frame");
	chk_enable_clock_low: assert property ($changed(enableN) |-> !sclk)
		else $error("enable moved while clock high");
	chk_sclk_high_time: assert property ($rose(sclk) |-> sclk[*7])
		else $error("clock high phase too short");
	chk_sclk_low_time: assert property ($fell(sclk) |-> !sclk[*7])
		else $error("clock low phase too short");
	chk_data_stable: assert property (sclk && $past(sclk) |-> $stable(sdata))
		else $error("data moved while clock high");
	chk_frame_length: assert property ($rose(enableN) |->
		count_q inside {5'h08, 5'h0F, 5'h10, 5'h18})
		else $error("frame length not accepted");
	chk_echo_drive_on: assert property (!enableN[*6] |-> dataOutOe)
		else $error("echo not driven in frame");
	chk_echo_drive_off: assert property (enableN[*8] |-> !dataOutOe)
		else $error("echo driven while idle");
	chk_echo_on_fall: assert property ($changed(dataOut) && dataOutOe &&
		$past(dataOutOe) |-> !sclk)
		else $error("echo changed while clock high");
	chk_echo_bit_value: assert property ($fell(sclk) && !enableN |->
		##5 (dataLine == heldBit_q))
		else $error("echo bit differs from sampled bit");
endmodule : synth_port_props

`default_nettype wire

/* tb/synth_serial_program_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module synth_serial_program_port_tb;
	import synth_port_pkg::*;

	localparam int SETTLE = 200;
	logic mclk = 1'b0, reset = 1'b1, start = 1'b0;
	frame_kind_t kind = KIND_SETUP;
	logic [23:0] word = 24'h000000;
	logic busy, done, refused, echoMatch, configured, freeRun;
	logic settling, locked, reject2;
	logic [23:0] echo;
	logic [7:0] setupByte, setupByte2;
	logic [15:0] loopMultiplier;
	logic [14:0] baseDivide, baseDivide2;
	logic [31:0] outFreqKhz;
	int checked = 0, badCount = 0, rejCount = 0;

	synth_link_if link ();
	synth_link_if link2 ();

	synth_port_host synth_port_host_inst (.mclk(mclk), .reset(reset),
		.link(link), .start(start), .kind(kind), .word(word),
		.busy(busy), .done(done), .refused(refused), .echo(echo),
		.echoMatch(echoMatch));
	synth_port_device #(.SETTLE_CYCLES(SETTLE)) synth_port_device_inst (
		.mclk(mclk), .reset(reset), .link(link), .setupByte(setupByte),
		.loopMultiplier(loopMultiplier), .baseDivide(baseDivide),
		.configured(configured), .freeRun(freeRun), .settling(settling),
		.locked(locked), .outFreqKhz(outFreqKhz), .commitPulse(),
		.rejectPulse());
	// Second device, pins driven by the bench
	synth_port_device #(.SETTLE_CYCLES(SETTLE)) synth_port_device_inst2 (
		.mclk(mclk), .reset(reset), .link(link2), .setupByte(setupByte2),
		.loopMultiplier(), .baseDivide(baseDivide2), .configured(),
		.freeRun(), .settling(), .locked(), .outFreqKhz(),
		.commitPulse(), .rejectPulse(reject2));
	synth_port_props synth_port_props_inst (.mclk(mclk), .reset(reset),
		.sclk(link.sclk), .enableN(link.enableN), .sdata(link.sdata),
		.dataOut(link.dataOut), .dataOutOe(link.dataOutOe),
		.dataLine(link.dataLine));

	// Clock and discard counter
	always #10 mclk = ~mclk;
	always @(posedge mclk) if (reject2 === 1'b1) rejCount++;

	//------------------------------
	// Tasks
	//------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			badCount++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : check

	task automatic completeRun();
		$display("comparisons %0d mismatches %0d", checked, badCount);
		if (badCount == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : completeRun

	// One host command and its answer
	task automatic send(input frame_kind_t k, input logic [23:0] w,
		input logic expRef, input logic [23:0] expEcho);
		logic seenRef;
		int n;
		seenRef = 1'b0;
		n = 0;
		@(negedge mclk);
		start = 1'b1;
		kind = k;
		word = w;
		@(negedge mclk);
		start = 1'b0;
		repeat (3)
		begin
			seenRef = seenRef | refused;
			@(negedge mclk);
		end
		check(seenRef, expRef);
		while (!expRef && done !== 1'b1 && n < 3000)
		begin
			@(negedge mclk);
			n++;
		end
		if (!expRef)
		begin
			check(done, 1'b1);
			check(busy, 1'b0);
			check(echo, expEcho);
			check(echoMatch, 1'b1);
		end
	endtask : send

	// Settle phase, then the new frequency
	task automatic settle(input logic [31:0] oldF, input logic [31:0] newF);
		check(settling, 1'b1);
		check(outFreqKhz, oldF);
		repeat (SETTLE + 10) @(negedge mclk);
		check(locked, 1'b1);
		check(outFreqKhz, newF);
	endtask : settle

	// Raw frame on the second link, any length up to 24
	task automatic raw(input int len, input logic [23:0] bits);
		@(negedge mclk);
		link2.enableN = 1'b0;
		repeat (7) @(negedge mclk);
		for (int i = len - 1; i >= 0; i--)
		begin
			link2.sdata = bits[i];
			repeat (7) @(negedge mclk);
			link2.sclk = 1'b1;
			repeat (7) @(negedge mclk);
			link2.sclk = 1'b0;
			repeat (7) @(negedge mclk);
		end
		link2.enableN = 1'b1;
		link2.sdata = ~link2.sdata;
		repeat (20) @(negedge mclk);
	endtask : raw

	// Main sequence
	initial
	begin
		link2.sclk = 1'b0;
		link2.enableN = 1'b1;
		link2.sdata = 1'b0;
		repeat (3) @(negedge mclk);
		reset = 1'b0;
		repeat (5) @(negedge mclk);
		check(freeRun, 1'b1);
		check(configured, 1'b0);
		check(outFreqKhz, 32'h000186A0);
		send(KIND_MULT, 24'h00607C, 1'b0, 24'h00607C);
		check(loopMultiplier, 16'h607C);
		send(KIND_DIV15, 24'h0007D0, 1'b0, 24'h0007D0);
		check(baseDivide, 15'h07D0);
		check(freeRun, 1'b1);
		send(KIND_SETUP, 24'h0000FF, 1'b0, 24'h000040);
		check(setupByte, 8'h40);
		check(configured, 1'b1);
		check(freeRun, 1'b0);
		settle(32'h000186A0, 32'h0001E26C);
		fork
			send(KIND_MULT, 24'h006AA4, 1'b0, 24'h006AA4);
			begin
				repeat (150) @(negedge mclk);
				check(loopMultiplier, 16'h607C);
			end
		join
		settle(32'h0001E26C, 32'h00021534);
		send(KIND_DIV24, 24'h0009C4, 1'b0, 24'h0009C4);
		check(baseDivide, 15'h09C4);
		settle(32'h00021534, 32'h0001AA90);
		send(KIND_DIV15, 24'h00063F, 1'b1, 24'h000000);
		send(KIND_DIV24, 24'h0009C5, 1'b1, 24'h000000);
		send(KIND_MULT, 24'h0061A7, 1'b1, 24'h000000);
		check(baseDivide, 15'h09C4);
		check(loopMultiplier, 16'h6AA4);
		raw(24, 24'hFF8640);
		check(baseDivide2, 15'h0640);
		raw(12, 24'h000ABC);
		check(rejCount, 32'h00000001);
		check(baseDivide2, 15'h0640);
		raw(8, 24'h000040);
		check(setupByte2, 8'h40);
		completeRun();
	end

	// Watchdog against a hung run
	initial
	begin
		repeat (40000) @(posedge mclk);
		badCount++;
		completeRun();
	end
endmodule : synth_serial_program_port_tb

`default_nettype wire
